// file: logic/rx_ring_manager.sv
/*
 Receive buffer ring manager: stores incoming frames into a ring of
 256-byte pages, links pages, wraps, aborts at the read pointer and
 writes the 4-byte frame header. APB register slave included.
 Assumes a receive front end that holds each request until RX_READY,
 and a byte-wide buffer memory port with a ready answer.
*/
// Register access over APB and the address map were chosen for this implementation.
// Behaviour
// - write pointer holds frame's first page; used for header and rejection
// - receive address reaching read pointer aborts the frame, stored frames kept
// - read pointer seeds remote start address; software advances it
// - frame starts at write pointer page, four header bytes skipped
// - full page links to the very next page, never skipping
// - next page equal to ring end redirects to ring first page
// - next page equal to read pointer aborts; else link proceeds
// - accepted frame: header written at first page with status, next, count
// - next frame begins on next free page; write pointer loaded with it
// - receive page reaching ring end resets to ring first page
// - equal pointers: empty if read caught up, full if write did
// - rejected frame resets address to write pointer unless accepted
`timescale 1ns/1ps
`include "ring_defines.svh"
module rx_ring_manager (
    input  wire logic              CORE_CLK,
    input  wire logic              NRST,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              RX_SOF,
    input  wire logic              RX_VALID,
    input  wire logic [7:0]        RX_DATA,
    input  wire logic              RX_END,
    input  wire ring_pkg::rx_end_t RX_END_INFO,
    output logic                   RX_READY,
    output logic                   MEM_VALID,
    output ring_pkg::mem_wr_t      MEM_WR,
    input  wire logic              MEM_READY,
    output logic      [15:0]       REMOTE_ADDR
);
    ring_pkg::rx_state_t state_r;
    ring_pkg::mem_wr_t   ld_wr;
    logic [2:0]  ctrl_r;
    logic [7:0]  first_r;
    logic [7:0]  stop_r;
    logic [7:0]  wp_r;
    logic [7:0]  rp_r;
    logic        ovr_r;
    logic        wrote_last_r;
    logic [15:0] cur_r;
    logic [15:0] cnt_r;
    logic [7:0]  next_pg_r;
    logic [7:0]  stat_r;
    logic [1:0]  hidx_r;
    logic [7:0]  step_pg;
    logic        mem_busy;
    logic        wr_en;
    logic        take;
    logic        at_page_end;
    logic        link_abort;
    logic        ring_full;
    logic        run;
    logic        sof_ok;
    logic        end_ok;
    logic        keep;
    logic        ld;
    logic        hdr_done;
    logic        mapped;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `RA_CTRL) || (a == `RA_FIRST) || (a == `RA_END) ||
                    (a == `RA_WPTR) || (a == `RA_RPTR) || (a == `RA_STATUS) ||
                    (a == `RA_REMOTE);
    endfunction : is_mapped

    // Header byte order: status, next page, count low, count high
    function automatic logic [7:0] hdr_byte(input logic [1:0] i);
        unique case (i)
            2'd0: hdr_byte = stat_r;
            2'd1: hdr_byte = next_pg_r;
            2'd2: hdr_byte = cnt_r[7:0];
            2'd3: hdr_byte = cnt_r[15:8];
        endcase
    endfunction : hdr_byte

    // ----------------------------------------------------------------
    // Combinational control terms
    // ----------------------------------------------------------------
    // Loopback keeps the receive DMA idle, as does the halt bit
    assign run         = !ctrl_r[`CTRL_HALT] && !ctrl_r[`CTRL_LOOP];
    assign ring_full   = (wp_r == rp_r) && wrote_last_r;
    assign mapped      = is_mapped(PADDR);
    assign wr_en       = PSEL && PENABLE && PWRITE && mapped;
    assign PREADY      = 1'b1;
    assign PSLVERR     = PSEL && PENABLE && !mapped;
    assign RX_READY    = (state_r == ring_pkg::ST_IDLE) ||
                         (state_r == ring_pkg::ST_DROP) ||
                         ((state_r == ring_pkg::ST_STORE) && !mem_busy);
    assign take        = (state_r == ring_pkg::ST_STORE) && RX_VALID && !mem_busy;
    assign at_page_end = (cur_r[7:0] == `PAGE_LAST);
    assign link_abort  = take && at_page_end && (step_pg == rp_r);
    assign sof_ok      = (state_r == ring_pkg::ST_IDLE) && RX_SOF && run;
    assign end_ok      = (state_r == ring_pkg::ST_STORE) && RX_END && !mem_busy &&
                         !RX_VALID;
    assign keep        = RX_END_INFO.good || ctrl_r[`CTRL_ACCBAD];
    assign ld          = take || ((state_r == ring_pkg::ST_HEADER) && !mem_busy);
    assign hdr_done    = (state_r == ring_pkg::ST_HEADER) && !mem_busy &&
                         (hidx_r == 2'd3);
    assign MEM_VALID   = mem_busy;

    // Header bytes go to the frame's first page, data to the running address
    always_comb begin
        if (state_r == ring_pkg::ST_HEADER) begin
            ld_wr.addr = {wp_r, 6'h00, hidx_r};
            ld_wr.data = hdr_byte(hidx_r);
        end else begin
            ld_wr.addr = cur_r;
            ld_wr.data = RX_DATA;
        end
    end

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    ring_page_step u_step (
        .page  (cur_r[15:8]),
        .first (first_r),
        .stop  (stop_r),
        .nxt   (step_pg)
    );

    ring_mem_port u_port (
        .clk   (CORE_CLK),
        .nrst  (NRST),
        .load  (ld),
        .wr    (ld_wr),
        .ready (MEM_READY),
        .busy  (mem_busy),
        .out   (MEM_WR)
    );

    // ----------------------------------------------------------------
    // Receive state machine
    // ----------------------------------------------------------------
    // A new frame is refused while the ring is full, same as a link abort
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            state_r <= ring_pkg::ST_IDLE;
        end else begin
            unique case (state_r)
                ring_pkg::ST_IDLE: begin
                    if (sof_ok) begin
                        state_r <= ring_full ? ring_pkg::ST_DROP
                                             : ring_pkg::ST_STORE;
                    end
                end
                ring_pkg::ST_STORE: begin
                    if (link_abort) begin
                        state_r <= ring_pkg::ST_DROP;
                    end else if (end_ok) begin
                        state_r <= keep ? ring_pkg::ST_HEADER
                                        : ring_pkg::ST_IDLE;
                    end
                end
                ring_pkg::ST_HEADER: begin
                    if (hdr_done) begin
                        state_r <= ring_pkg::ST_IDLE;
                    end
                end
                ring_pkg::ST_DROP: begin
                    if (RX_END) begin
                        state_r <= ring_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Running byte address; rejection simply restarts at the write pointer
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            cur_r <= '0;
        end else if (sof_ok) begin
            cur_r <= {wp_r, `HDR_BYTES};
        end else if (take && at_page_end) begin
            cur_r <= {step_pg, 8'h00};
        end else if (take) begin
            cur_r <= cur_r + 16'h0001;
        end
    end

    // Byte count and status captured for the header
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            cnt_r  <= '0;
            stat_r <= '0;
        end else if (sof_ok) begin
            cnt_r <= '0;
        end else if (take) begin
            cnt_r <= cnt_r + 16'h0001;
        end else if (end_ok) begin
            stat_r <= RX_END_INFO.status;
        end
    end

    // Next frame page: unused tail of the last page is given up
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            next_pg_r <= `PAGE_RST;
        end else if (end_ok) begin
            next_pg_r <= (cur_r[7:0] == 8'h00) ? cur_r[15:8] : step_pg;
        end
    end

    // Header byte index
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            hidx_r <= 2'd0;
        end else if (state_r != ring_pkg::ST_HEADER) begin
            hidx_r <= 2'd0;
        end else if (!mem_busy) begin
            hidx_r <= hidx_r + 2'd1;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Static ring bounds and control; zero first page is the host's worry
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            ctrl_r  <= `CTRL_RST;
            first_r <= `PAGE_RST;
            stop_r  <= `PAGE_RST + 8'h01;
        end else if (wr_en) begin
            if (PADDR == `RA_CTRL) begin
                ctrl_r <= PWDATA[2:0];
            end
            if (PADDR == `RA_FIRST) begin
                first_r <= PWDATA[7:0];
            end
            if (PADDR == `RA_END) begin
                stop_r <= PWDATA[7:0];
            end
        end
    end

    // Write pointer: hardware load after a header wins over software
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            wp_r <= `PAGE_RST;
        end else if (hdr_done) begin
            wp_r <= next_pg_r;
        end else if (wr_en && (PADDR == `RA_WPTR)) begin
            wp_r <= PWDATA[7:0];
        end
    end

    // Read pointer: software advances it once a frame is removed
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            rp_r <= `PAGE_RST;
        end else if (wr_en && (PADDR == `RA_RPTR)) begin
            rp_r <= PWDATA[7:0];
        end
    end

    // Which pointer moved last tells full from empty; write move wins
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            wrote_last_r <= 1'b0;
        end else if (hdr_done) begin
            wrote_last_r <= (next_pg_r == rp_r);
        end else if (wr_en && ((PADDR == `RA_RPTR) || (PADDR == `RA_WPTR))) begin
            wrote_last_r <= 1'b0;
        end
    end

    // Sticky overrun, write one to clear; a new abort beats the clear
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            ovr_r <= 1'b0;
        end else if (link_abort || (sof_ok && ring_full)) begin
            ovr_r <= 1'b1;
        end else if (wr_en && (PADDR == `RA_STATUS) && PWDATA[`ST_OVR]) begin
            ovr_r <= 1'b0;
        end
    end

    // Remote transfer start follows the read pointer
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            REMOTE_ADDR <= '0;
        end else begin
            REMOTE_ADDR <= {rp_r, 8'h00};
        end
    end

    // Read data captured in the setup cycle, stable through access
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            PRDATA <= '0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
                `RA_CTRL:   PRDATA <= {29'h0, ctrl_r};
                `RA_FIRST:  PRDATA <= {24'h0, first_r};
                `RA_END:    PRDATA <= {24'h0, stop_r};
                `RA_WPTR:   PRDATA <= {24'h0, wp_r};
                `RA_RPTR:   PRDATA <= {24'h0, rp_r};
                `RA_STATUS: PRDATA <= {28'h0, (wp_r == rp_r) && !wrote_last_r,
                                       state_r != ring_pkg::ST_IDLE, ring_full, ovr_r};
                `RA_REMOTE: PRDATA <= {16'h0, REMOTE_ADDR};
                default:    PRDATA <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence s_link;
        take && at_page_end && (step_pg != rp_r);
    endsequence

    sequence s_accept;
        end_ok && keep;
    endsequence

    chk_frame_start: assert property (sof_ok && !ring_full |=>
        cur_r == {$past(wp_r), 8'h04} && state_r == ring_pkg::ST_STORE)
        else $error("frame not started after header gap");
    chk_link_next: assert property (s_link |=> cur_r[7:0] == 8'h00 &&
        cur_r[15:8] != stop_r && state_r == ring_pkg::ST_STORE)
        else $error("page link wrong");
    chk_wrap_first: assert property (s_link and (cur_r[15:8] + 8'h01 == stop_r) |=>
        cur_r[15:8] == first_r)
        else $error("ring end not wrapped");
    chk_abort_read: assert property (link_abort |=>
        state_r == ring_pkg::ST_DROP && ovr_r)
        else $error("read pointer not protected");
    chk_reject_back: assert property (end_ok && !keep |=>
        state_r == ring_pkg::ST_IDLE && $stable(wp_r))
        else $error("rejected frame not reclaimed");
    chk_header_seq: assert property (s_accept |=>
        (state_r == ring_pkg::ST_HEADER)[*1] ##0 (ld_wr.addr[15:8] == wp_r)[*1])
        else $error("header not at first page");
    chk_header_page: assert property (ld && state_r == ring_pkg::ST_HEADER |=>
        MEM_WR.addr[15:8] == $past(wp_r) && MEM_VALID)
        else $error("header page mismatch");
    chk_wp_load: assert property (hdr_done |=> wp_r == $past(next_pg_r) &&
        state_r == ring_pkg::ST_IDLE)
        else $error("write pointer not advanced");
    chk_empty_full: assert property (sof_ok && (wp_r == rp_r) && !wrote_last_r |=>
        state_r == ring_pkg::ST_STORE)
        else $error("empty ring seen full");
    chk_remote_seed: assert property ($changed(rp_r) |=>
        REMOTE_ADDR == {$past(rp_r), 8'h00})
        else $error("remote start not seeded");
endmodule : rx_ring_manager

// file: logic/ring_defines.svh
/*
 Register offsets, field positions, reset values and fixed sizes of the
 receive ring manager. Assumes inclusion by bare name from logic files.
*/
`ifndef RING_DEFINES_SVH
`define RING_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RA_CTRL      8'h00
`define RA_FIRST     8'h04
`define RA_END       8'h08
`define RA_WPTR      8'h0c
`define RA_RPTR      8'h10
`define RA_STATUS    8'h14
`define RA_REMOTE    8'h18

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CTRL_HALT    0
`define CTRL_LOOP    1
`define CTRL_ACCBAD  2
`define CTRL_RST     3'h1
`define ST_OVR       0
`define ST_FULL      1
`define ST_BUSY      2
`define ST_EMPTY     3
`define PAGE_RST     8'h01
`define HDR_BYTES    8'h04
`define PAGE_LAST    8'hff

`endif

// file: logic/ring_pkg.sv
/*
 Types shared by the receive ring manager files.
 Assumes nothing of its surroundings.
*/
package ring_pkg;
    // One-hot receive states
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_STORE  = 4'b0010,
        ST_HEADER = 4'b0100,
        ST_DROP   = 4'b1000
    } rx_state_t;

    // One byte write into buffer memory
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } mem_wr_t;

    // End-of-frame verdict from the receive front end
    typedef struct packed {
        logic       good;
        logic [7:0] status;
    } rx_end_t;
endpackage : ring_pkg

// file: logic/ring_page_step.sv
/*
 Next page of the receive ring, with wrap at the ring end page.
 Assumes first < end, both programmed by software.
*/
`timescale 1ns/1ps
module ring_page_step (
    input  wire logic [7:0] page,
    input  wire logic [7:0] first,
    input  wire logic [7:0] stop,
    output logic      [7:0] nxt
);
    logic [7:0] inc;

    // ----------------------------------------------------------------
    // Forward link
    // ----------------------------------------------------------------
    // The end page is never used; reaching it means the ring start
    always_comb begin
        inc = page + 8'h01;
        nxt = (inc == stop) ? first : inc;
    end
endmodule : ring_page_step

// file: logic/ring_mem_port.sv
/*
 One-entry holding register for byte writes into buffer memory.
 Assumes the memory side answers with ready at some later edge.
*/
`timescale 1ns/1ps
module ring_mem_port (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             load,
    input  wire ring_pkg::mem_wr_t wr,
    input  wire logic             ready,
    output logic                  busy,
    output ring_pkg::mem_wr_t     out
);
    // ----------------------------------------------------------------
    // Pending flag and held write
    // ----------------------------------------------------------------
    // Load is only issued while idle, so a load never meets a drain
    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy <= 1'b0;
        end else if (load) begin
            busy <= 1'b1;
        end else if (ready) begin
            busy <= 1'b0;
        end
    end

    // Address and data stand until the memory takes them
    always_ff @(posedge clk) begin
        if (!nrst) begin
            out <= '0;
        end else if (load) begin
            out <= wr;
        end
    end
endmodule : ring_mem_port

// file: bench/buf_mem_model.sv
/*
 Byte-wide buffer memory on the far side of the receive ring manager.
 Assumes the write port holds each request until it is taken with ready.
*/
`timescale 1ns/1ps
module buf_mem_model (
    input  wire logic              clk,
    input  wire logic              slow,
    input  wire logic              mem_valid,
    input  wire ring_pkg::mem_wr_t mem_wr,
    output logic                   mem_ready
);
    // ------------------------------------------------------------
    // Storage and stall pattern
    // ------------------------------------------------------------
    logic [7:0] mem [0:65535];
    logic       phase = 1'b0;

    // Slow mode answers only on every second edge, so the port must hold
    assign mem_ready = ~slow | phase;

    // A byte lands only at an edge where both sides agree
    always @(posedge clk) begin
        phase <= ~phase;
        if (mem_valid && mem_ready) begin
            mem[mem_wr.addr] <= mem_wr.data;
        end
    end
endmodule : buf_mem_model

// file: bench/tb.sv
/*
 Self-checking bench for the receive ring manager: APB host tasks,
 a frame source task and a byte memory model on the far side.
 Assumes the register map and reset values of the ring defines header.
*/
`timescale 1ns/1ps
`include "ring_defines.svh"
module tb;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic                clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]          paddr, rx_data;
    logic [31:0]         pwdata, prdata, rdq;
    logic                rx_sof, rx_valid, rx_end, rx_ready, mem_valid, mem_ready;
    logic                slow, errq;
    ring_pkg::rx_end_t   end_info;
    ring_pkg::mem_wr_t   mem_wr;
    logic [15:0]         remote_addr;
    int                  n_mismatch = 0;
    int                  checks_done = 0;
    logic [7:0]          ra [5] = '{`RA_CTRL, `RA_FIRST, `RA_END, `RA_WPTR, `RA_RPTR};
    logic [31:0]         rv [5] = '{32'h1, 32'h1, 32'h2, 32'h1, 32'h1};

    rx_ring_manager dut_u (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RX_SOF(rx_sof), .RX_VALID(rx_valid),
        .RX_DATA(rx_data), .RX_END(rx_end), .RX_END_INFO(end_info),
        .RX_READY(rx_ready), .MEM_VALID(mem_valid), .MEM_WR(mem_wr),
        .MEM_READY(mem_ready), .REMOTE_ADDR(remote_addr));
    buf_mem_model mem_u (.clk(clk), .slow(slow), .mem_valid(mem_valid),
        .mem_wr(mem_wr), .mem_ready(mem_ready));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // Values are taken in the half cycle before the edge, so no race
    task automatic wait_edge(input bit on_rx);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (((on_rx ? rx_ready : pready) !== 1'b1) && n < 2000);
        rdq = prdata;
        errq = pslverr;
        if (n >= 2000) cmp(32'h0, 32'h1);
        @(posedge clk);
    endtask : wait_edge

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        wait_edge(1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(rdq, exp);
    endtask : rd_chk

    task automatic st_chk(input int bit_no, input logic val);
        apb(1'b0, `RA_STATUS, 32'h0);
        cmp({31'h0, rdq[bit_no]}, {31'h0, val});
    endtask : st_chk

    task automatic mchk(input logic [15:0] a, input logic [7:0] exp);
        cmp({24'h0, mem_u.mem[a]}, {24'h0, exp});
    endtask : mchk

    // Byte i of a frame carries seed + i; waits until the header is out
    task automatic send_frame(input int len, input logic good, input logic [7:0] st,
                              input logic [7:0] seed);
        int i;
        int n;
        @(posedge clk);
        rx_sof <= 1'b1;
        wait_edge(1'b1);
        rx_sof <= 1'b0;
        for (i = 0; i < len; i++) begin
            rx_valid <= 1'b1;
            rx_data <= seed + i[7:0];
            wait_edge(1'b1);
        end
        rx_valid <= 1'b0;
        rx_end <= 1'b1;
        end_info <= '{good: good, status: st};
        wait_edge(1'b1);
        rx_end <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(rx_ready === 1'b1 && mem_valid === 1'b0) && n < 100);
    endtask : send_frame

    // ------------------------------------------------------------
    // Clock, reset and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Frames total some 1715 bytes at up to 3 cycles each
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        close_out();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, psel, penable, pwrite, rx_sof, rx_valid, rx_end, slow} = 8'h00;
        {paddr, rx_data, pwdata} = 48'h0;
        end_info = '0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 5; k++) rd_chk(ra[k], rv[k]);
        rd_chk(8'h20, 32'h0);
        cmp({31'h0, errq}, 32'h1);
        cmp({16'h0, remote_addr}, 32'h0100);
        apb(1'b1, `RA_FIRST, 32'h10);
        apb(1'b1, `RA_END, 32'h14);
        apb(1'b1, `RA_RPTR, 32'h10);
        apb(1'b1, `RA_WPTR, 32'h10);
        apb(1'b1, `RA_CTRL, 32'h0);
        cmp({16'h0, remote_addr}, 32'h1000);
        // Long frame over a stalling memory: offset, link, header
        slow <= 1'b1;
        send_frame(300, 1'b1, 8'h01, 8'h00);
        slow <= 1'b0;
        mchk(16'h1004, 8'h00);
        mchk(16'h10ff, 8'hfb);
        mchk(16'h1100, 8'hfc);
        mchk(16'h1000, 8'h01);
        mchk(16'h1001, 8'h12);
        mchk(16'h1002, 8'h2c);
        mchk(16'h1003, 8'h01);
        rd_chk(`RA_WPTR, 32'h12);
        // Rejected frame leaves the write pointer for the next one
        send_frame(10, 1'b0, 8'h02, 8'h40);
        rd_chk(`RA_WPTR, 32'h12);
        apb(1'b1, `RA_RPTR, 32'h11);
        send_frame(600, 1'b1, 8'h21, 8'h80);
        mchk(16'h1204, 8'h80);
        mchk(16'h1000, 8'h7c);
        mchk(16'h1201, 8'h11);
        mchk(16'h1202, 8'h58);
        mchk(16'h1203, 8'h02);
        rd_chk(`RA_WPTR, 32'h11);
        st_chk(`ST_FULL, 1'b1);
        // Full ring: the frame is dropped, stored data stays
        send_frame(5, 1'b1, 8'h01, 8'h33);
        st_chk(`ST_OVR, 1'b1);
        rd_chk(`RA_WPTR, 32'h11);
        mchk(16'h1100, 8'hfc);
        // Host recovery: halt, drain, clear overrun, restart
        apb(1'b1, `RA_CTRL, 32'h1);
        rd_chk(`RA_CTRL, 32'h1);
        // Nothing is in flight here, so a short pause stands for the long one
        repeat (20) @(posedge clk);
        apb(1'b1, `RA_REMOTE, 32'h0);
        apb(1'b1, `RA_CTRL, 32'h2);
        apb(1'b1, `RA_RPTR, 32'h10);
        apb(1'b1, `RA_STATUS, 32'h1);
        apb(1'b1, `RA_CTRL, 32'h0);
        st_chk(`ST_OVR, 1'b0);
        cmp({16'h0, remote_addr}, 32'h1000);
        // Link onto the read page aborts the frame
        send_frame(800, 1'b1, 8'h01, 8'h10);
        mchk(16'h1304, 8'h10);
        st_chk(`ST_OVR, 1'b1);
        rd_chk(`RA_WPTR, 32'h11);
        mchk(16'h1000, 8'h7c);
        close_out();
    end
endmodule : tb
